// >>> rtl/asr_host.sv
`timescale 1ns/100ps
// Notes on behaviour
// - primary select low, secondary high
// - host releases data when memory drives
// - address held 35 ns before write end
// - write data stable 25 ns before end
module asr_host
	import asr_pkg::*;
(
	// clock and reset
	input  wire logic                      core_clk,
	input  wire logic                      resetn,
	input  wire logic                      clk_en,
	// request side
	input  wire logic                      req_valid,
	output logic                           req_ready,
	input  wire asr_pkg::asr_req_t         req,
	output logic [asr_pkg::DATA_W-1:0]     rsp_rdata,
	output logic                           rsp_rvalid,
	output logic                           rsp_wdone,
	// memory pins
	output logic [asr_pkg::ADDR_W-1:0]     address_lines,
	output logic                           primary_select_n,
	output logic                           secondary_select,
	output logic                           write_n,
	output logic                           output_enable_n,
	output logic [asr_pkg::DATA_W-1:0]     data_lines_out,
	output logic                           data_lines_oe_n,
	input  wire logic [asr_pkg::DATA_W-1:0] data_lines_in
);
	import asr_pkg::*;

	// ************************
	// pin input sync
	// ************************
	logic [DATA_W-1:0] din_s1_q;
	logic [DATA_W-1:0] din_s2_q;
	logic [DATA_W-1:0] din_s3_q;

	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			din_s1_q <= '0;
			din_s2_q <= '0;
			din_s3_q <= '0;
		end else if (clk_en) begin
			din_s1_q <= data_lines_in;
			din_s2_q <= din_s1_q;
			din_s3_q <= din_s2_q;
		end
	end

	logic din_stable;
	assign din_stable = (din_s2_q == din_s3_q);

	// ************************
	// state
	// ************************
	asr_regs_t r_q;
	asr_regs_t r_d;

	function automatic asr_pins_t idle_pins(input asr_pins_t p);
		asr_pins_t o;
		o                  = p;
		o.primary_select_n = 1'b1;
		o.secondary_select = 1'b0;
		o.write_n          = 1'b1;
		o.output_enable_n  = 1'b1;
		o.data_oe_n        = 1'b1;
		return o;
	endfunction

	localparam asr_regs_t REGS_RST = '{
		state: ASR_IDLE,
		cnt: '0,
		pins: '{address_lines: '0, primary_select_n: 1'b1, secondary_select: 1'b0,
			write_n: 1'b1, output_enable_n: 1'b1, data_out: '0, data_oe_n: 1'b1},
		rdata: '0,
		rvalid: 1'b0,
		wdone: 1'b0
	};

	assign req_ready = (r_q.state == ASR_IDLE);

	always_comb begin
		r_d        = r_q;
		r_d.rvalid = 1'b0;
		r_d.wdone  = 1'b0;
		case (r_q.state)
			ASR_IDLE: begin
				if (req_valid) begin
					r_d.pins.address_lines    = req.addr;
					r_d.pins.primary_select_n = 1'b0;
					r_d.pins.secondary_select = 1'b1;
					if (req.write) begin
						r_d.pins.write_n   = 1'b0;
						r_d.pins.data_out  = req.wdata;
						r_d.pins.data_oe_n = 1'b0;
						r_d.cnt            = CNT_W'(WP_CYC - 1);
						r_d.state          = ASR_WRITE;
					end else begin
						r_d.pins.output_enable_n = 1'b0;
						r_d.pins.data_oe_n       = 1'b1;
						r_d.cnt                  = CNT_W'(RD_CYC - 1);
						r_d.state                = ASR_READ;
					end
				end
			end
			ASR_WRITE: begin
				if (r_q.cnt != '0) begin
					r_d.cnt = r_q.cnt - 1'b1;
				end else begin
					r_d.pins  = idle_pins(r_q.pins);
					r_d.wdone = 1'b1;
					r_d.cnt   = CNT_W'(RC_CYC - 1);
					r_d.state = ASR_RECOVER;
				end
			end
			ASR_READ: begin
				if (r_q.cnt != '0) begin
					r_d.cnt = r_q.cnt - 1'b1;
				end else if (din_stable) begin
					r_d.rdata  = din_s3_q;
					r_d.rvalid = 1'b1;
					r_d.pins   = idle_pins(r_q.pins);
					r_d.cnt    = CNT_W'(RC_CYC - 1);
					r_d.state  = ASR_RECOVER;
				end
			end
			ASR_RECOVER: begin
				if (r_q.cnt != '0) begin
					r_d.cnt = r_q.cnt - 1'b1;
				end else begin
					r_d.state = ASR_IDLE;
				end
			end
			default: begin
				r_d = REGS_RST;
			end
		endcase
	end

	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			r_q <= REGS_RST;
		end else if (clk_en) begin
			r_q <= r_d;
		end
	end

	// ************************
	// outputs
	// ************************
	assign address_lines    = r_q.pins.address_lines;
	assign primary_select_n = r_q.pins.primary_select_n;
	assign secondary_select = r_q.pins.secondary_select;
	assign write_n          = r_q.pins.write_n;
	assign output_enable_n  = r_q.pins.output_enable_n;
	assign data_lines_out   = r_q.pins.data_out;
	assign data_lines_oe_n  = r_q.pins.data_oe_n;
	assign rsp_rdata        = r_q.rdata;
	assign rsp_rvalid       = r_q.rvalid;
	assign rsp_wdone        = r_q.wdone;

	// ************************
	// assertions
	// ************************
	property p_no_drive_when_oe;
		@(posedge core_clk) disable iff (!resetn)
		!output_enable_n |-> data_lines_oe_n;
	endproperty
	a_no_drive_when_oe: assert property (p_no_drive_when_oe)
		else $error("host drives data while memory enabled");

	property p_write_needs_select;
		@(posedge core_clk) disable iff (!resetn)
		!write_n |-> (!primary_select_n && secondary_select && output_enable_n);
	endproperty
	a_write_needs_select: assert property (p_write_needs_select)
		else $error("write strobe without both selects");

	property p_write_width;
		@(posedge core_clk) disable iff (!resetn)
		$fell(write_n) |-> !write_n [*8] ##1 !write_n;
	endproperty
	a_write_width: assert property (p_write_width)
		else $error("write pulse too short");

	property p_data_stable_in_write;
		@(posedge core_clk) disable iff (!resetn)
		(!write_n && !$past(write_n)) |-> ($stable(data_lines_out) && $stable(address_lines));
	endproperty
	a_data_stable_in_write: assert property (p_data_stable_in_write)
		else $error("data or address moved during write");

	property p_write_ends_together;
		@(posedge core_clk) disable iff (!resetn)
		$rose(write_n) |-> (primary_select_n && data_lines_oe_n);
	endproperty
	a_write_ends_together: assert property (p_write_ends_together)
		else $error("write ended without deselect");

	property p_recover_gap;
		@(posedge core_clk) disable iff (!resetn)
		(clk_en && $rose(primary_select_n)) |-> primary_select_n [*5];
	endproperty
	a_recover_gap: assert property (p_recover_gap)
		else $error("reselect before release time");

	property p_read_select;
		@(posedge core_clk) disable iff (!resetn)
		!output_enable_n |-> (write_n && !primary_select_n && secondary_select);
	endproperty
	a_read_select: assert property (p_read_select)
		else $error("output enable outside read");

	property p_rvalid_after_read;
		@(posedge core_clk) disable iff (!resetn)
		rsp_rvalid |-> (!$past(output_enable_n) && primary_select_n);
	endproperty
	a_rvalid_after_read: assert property (p_rvalid_after_read)
		else $error("read data without read cycle");

	c_write: cover property (@(posedge core_clk) disable iff (!resetn) rsp_wdone);
	c_read: cover property (@(posedge core_clk) disable iff (!resetn) rsp_rvalid);
	c_back: cover property (@(posedge core_clk) disable iff (!resetn)
		rsp_wdone ##[1:40] rsp_rvalid);
endmodule // asr_host

// >>> inc/asr_pkg.sv
package asr_pkg;
	// ************************
	// widths
	// ************************
	localparam int ADDR_W = 18;
	localparam int DATA_W = 8;
	localparam int CNT_W  = 5;
	// ************************
	// timing, fastest grade
	// ************************
	localparam int CLK_PERIOD_PS = 4000;
	localparam int T_AW_PS       = 35000;
	localparam int T_DW_PS       = 25000;
	localparam int T_AA_PS       = 45000;
	localparam int T_HZ_PS       = 18000;
	localparam int T_OW_PS       = 5000;
	// least times round up
	localparam int WP_CYC = (T_AW_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int RD_CYC = (T_AA_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS + 1;
	localparam int HZ_CYC = (T_HZ_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int OW_CYC = (T_OW_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int RC_CYC = (HZ_CYC > OW_CYC) ? HZ_CYC : OW_CYC;

	typedef enum logic [2:0] {
		ASR_IDLE,
		ASR_WRITE,
		ASR_READ,
		ASR_RECOVER
	} asr_state_t;

	// ************************
	// carriers
	// ************************
	typedef struct packed {
		logic              write;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
	} asr_req_t;

	typedef struct packed {
		logic [ADDR_W-1:0] address_lines;
		logic              primary_select_n;
		logic              secondary_select;
		logic              write_n;
		logic              output_enable_n;
		logic [DATA_W-1:0] data_out;
		logic              data_oe_n;
	} asr_pins_t;

	typedef struct packed {
		asr_state_t        state;
		logic [CNT_W-1:0]  cnt;
		asr_pins_t         pins;
		logic [DATA_W-1:0] rdata;
		logic              rvalid;
		logic              wdone;
	} asr_regs_t;
endpackage

// >>> tb/asr_sram_model.sv
`timescale 1ns/100ps
// ************************
// behavioural memory at the far side
// ************************
module asr_sram_model
	import asr_pkg::*;
(
	// host pins
	input  wire logic [asr_pkg::ADDR_W-1:0] address_lines,
	input  wire logic                       primary_select_n,
	input  wire logic                       secondary_select,
	input  wire logic                       write_n,
	input  wire logic                       output_enable_n,
	input  wire logic [asr_pkg::DATA_W-1:0] data_lines_out,
	input  wire logic                       data_lines_oe_n,
	// answer speed
	input  wire logic                       slow,
	// wire level
	output logic [asr_pkg::DATA_W-1:0]      data_lines
);
	import asr_pkg::*;
	logic [DATA_W-1:0] mem [0:(1<<ADDR_W)-1];
	logic [DATA_W-1:0] junk = 8'h5a;
	logic              rd_ok = 1'b0;
	logic              sel;
	logic              drv;
	logic              wr_on;
	logic [ADDR_W-1:0] wa;
	logic [DATA_W-1:0] wd;
	assign sel = !primary_select_n && secondary_select;
	assign drv = sel && write_n && !output_enable_n;
	// floating lines show a changing pattern
	always #4 junk = ~junk;
	always @(posedge drv or address_lines) begin
		rd_ok = 1'b0;
		#(slow ? 44 : 5) rd_ok = drv;
	end
	always @(negedge drv) rd_ok = 1'b0;
	assign wr_on = sel && !write_n;
	// latch while the host drives, commit when the write ends
	always @* if (wr_on && !data_lines_oe_n) begin
		wa = address_lines;
		wd = data_lines;
	end
	always @(negedge wr_on) mem[wa] = wd;
	assign data_lines = !data_lines_oe_n ? data_lines_out :
		(rd_ok ? mem[address_lines] : junk);
endmodule // asr_sram_model

// >>> tb/asr_host_tb.sv
`timescale 1ns/100ps
module asr_host_tb;
	import asr_pkg::*;
	logic              core_clk;
	logic              resetn;
	logic              clk_en;
	logic              req_valid;
	logic              req_ready;
	asr_req_t          req;
	logic [DATA_W-1:0] rsp_rdata;
	logic              rsp_rvalid;
	logic              rsp_wdone;
	logic [ADDR_W-1:0] address_lines;
	logic              primary_select_n;
	logic              secondary_select;
	logic              write_n;
	logic              output_enable_n;
	logic [DATA_W-1:0] data_lines_out;
	logic              data_lines_oe_n;
	logic [DATA_W-1:0] data_lines;
	logic              slow;
	logic [31:0]       seed = 32'h00000016;
	logic [ADDR_W-1:0] a;
	logic [ADDR_W-1:0] pa;
	logic [DATA_W-1:0] d;
	logic [DATA_W-1:0] pd;
	int                fail_count = 0;
	int                num_checks = 0;

	asr_host uut (.core_clk(core_clk), .resetn(resetn), .clk_en(clk_en),
		.req_valid(req_valid), .req_ready(req_ready), .req(req), .rsp_rdata(rsp_rdata),
		.rsp_rvalid(rsp_rvalid), .rsp_wdone(rsp_wdone), .address_lines(address_lines),
		.primary_select_n(primary_select_n), .secondary_select(secondary_select),
		.write_n(write_n), .output_enable_n(output_enable_n),
		.data_lines_out(data_lines_out), .data_lines_oe_n(data_lines_oe_n),
		.data_lines_in(data_lines));
	asr_sram_model mem_model (.address_lines(address_lines),
		.primary_select_n(primary_select_n), .secondary_select(secondary_select),
		.write_n(write_n), .output_enable_n(output_enable_n),
		.data_lines_out(data_lines_out), .data_lines_oe_n(data_lines_oe_n),
		.slow(slow), .data_lines(data_lines));

	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			fail_count++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic conclude();
		if (fail_count == 0 && num_checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	task automatic access(input logic wr, input logic [ADDR_W-1:0] ad, input logic [DATA_W-1:0] dt);
		int n;
		int k;
		n = 0;
		k = 0;
		while (req_ready !== 1'b1 && k < 100) begin
			k++;
			@(negedge core_clk);
		end
		check({31'h0, req_ready}, 32'h1);
		k = 0;
		req_valid = 1'b1;
		req = '{wr, ad, dt};
		@(negedge core_clk);
		req_valid = 1'b0;
		while (rsp_wdone !== 1'b1 && rsp_rvalid !== 1'b1 && k < 100) begin
			if (primary_select_n === 1'b0 && write_n === 1'b0) n++;
			if (k == 2) begin
				check(32'(address_lines), 32'(ad));
				check({primary_select_n, secondary_select, data_lines_oe_n, output_enable_n},
					wr ? 4'b0101 : 4'b0110);
				if (wr) check(32'(data_lines_out), 32'(dt));
			end
			k++;
			@(negedge core_clk);
		end
		check(32'(n), wr ? 32'(WP_CYC) : 32'h0);
		check({31'h0, wr ? rsp_wdone : rsp_rvalid}, 32'h1);
		if (!wr) check(32'(rsp_rdata), 32'(dt));
		@(negedge core_clk);
		check({primary_select_n, secondary_select, rsp_wdone, rsp_rvalid}, 4'b1000);
	endtask

	task automatic start_write(input logic [ADDR_W-1:0] ad, input logic [DATA_W-1:0] dt);
		while (req_ready !== 1'b1) @(negedge core_clk);
		req_valid = 1'b1;
		req = '{1'b1, ad, dt};
		@(negedge core_clk);
		req_valid = 1'b0;
	endtask

	initial begin
		core_clk = 1'b0;
		forever #2 core_clk = ~core_clk;
	end

	initial begin
		resetn = 1'b0;
		clk_en = 1'b1;
		req_valid = 1'b0;
		req = '0;
		slow = 1'b0;
		repeat (2) @(negedge core_clk);
		resetn = 1'b1;
		// ************************
		// corners and back-to-back
		// ************************
		access(1'b1, 18'h00000, 8'ha5);
		access(1'b1, 18'h3ffff, 8'h5a);
		access(1'b0, 18'h00000, 8'ha5);
		slow = 1'b1;
		access(1'b0, 18'h3ffff, 8'h5a);
		access(1'b1, 18'h00005, 8'h11);
		access(1'b1, 18'h00005, 8'hee);
		pa = 18'h00005;
		pd = 8'hee;
		// ************************
		// clock enable freeze mid-write
		// ************************
		start_write(18'h00009, 8'h3c);
		clk_en = 1'b0;
		repeat (20) @(negedge core_clk);
		check({primary_select_n, write_n, data_lines_oe_n, rsp_wdone}, 4'b0000);
		clk_en = 1'b1;
		access(1'b0, 18'h00009, 8'h3c);
		// ************************
		// random traffic
		// ************************
		for (int i = 0; i < 40; i++) begin
			a = rnd() & 18'h3ffff;
			d = rnd() & 8'hff;
			slow = rnd() & 1;
			access(1'b0, pa, pd);
			access(1'b1, a, d);
			pa = a;
			pd = d;
		end
		// ************************
		// reset in mid-write
		// ************************
		start_write(18'h00005, 8'h77);
		repeat (3) @(negedge core_clk);
		resetn = 1'b0;
		#1;
		check({primary_select_n, secondary_select, write_n, output_enable_n, data_lines_oe_n,
			req_ready}, 6'b101111);
		repeat (2) @(negedge core_clk);
		resetn = 1'b1;
		access(1'b0, pa, pd);
		conclude();
	end

	initial begin
		#60000;
		fail_count++;
		conclude();
	end
endmodule // asr_host_tb
